// >>> core/frame_memory_pixel_panel_out.sv
// Frame store, palette, APB register file and parallel RGB panel output.
// Assumes an APB master on the core clock and a panel that samples data on rising pixel clock.
// Behaviour
// - Embedded 32Mb frame store read continuously.
// - Timing registers set refresh interval, default 64ms.
// - Writing one to init bit starts initialisation.
// - Init done bit reads one when complete.
// - 16-bit words hold two 3:3:2 pixels.
// - 16-bit words hold one 5:6:5 pixel.
// - Two 8:8:8 pixels span three words.
// - Index bytes hold 2-bit opacity, 6-bit index.
// - 2-bit opacity weights 0, 11, 20, 32.
// - 16-bit words hold 4:4:4:4 opacity pixel.
// - 4-bit opacity weights 2n/32, fifteen full.
// - Palette entries hold 4:4:4 colour.
// - Palette has 64 entries of 4096 colours.
// - Bus width field selects 16, 18, 24 bits.
// - 24-bit mode maps blue, green, red bytes.
// - 16-bit mode maps 5:6:5 onto top lines.
// - 18-bit mode maps 6:6:6 onto top lines.
// - Outputs pixel clock, syncs and data enable.
module frame_memory_pixel_panel_out #(
	parameter int INIT_CYCLES = panel_out_pkg::INIT_CYCLES,
	parameter int H_ACTIVE    = 320,
	parameter int H_FRONT     = 20,
	parameter int H_SYNC      = 10,
	parameter int H_BACK      = 38,
	parameter int V_ACTIVE    = 240,
	parameter int V_FRONT     = 4,
	parameter int V_SYNC      = 2,
	parameter int V_BACK      = 14
) (
	input  wire logic        MCLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	output logic             PCLK_OUT,
	output logic             HSYNC_N_OUT,
	output logic             VSYNC_N_OUT,
	output logic             DE_OUT,
	output logic      [23:0] PANEL_PIXEL_LINES_OUT
);
	import panel_out_pkg::*;

	localparam int H_TOTAL = H_ACTIVE + H_FRONT + H_SYNC + H_BACK;
	localparam int V_TOTAL = V_ACTIVE + V_FRONT + V_SYNC + V_BACK;

	typedef enum {F_IDLE, F_RD0, F_RD1, F_RD2, F_PAL} fetch_state_t;

	mem_port_if #(.AW(FS_AW), .DW(FS_DW))   fs ();
	mem_port_if #(.AW(PAL_AW), .DW(PAL_DW)) pal ();

	word_mem #(.DEPTH(FS_DEPTH)) u_frame_store (
		.MCLK_IN (MCLK_IN),
		.port    (fs)
	);

	word_mem #(.DEPTH(PAL_DEPTH)) u_palette (
		.MCLK_IN (MCLK_IN),
		.port    (pal)
	);

	logic              pready_r;
	logic              pslverr_r;
	logic [31:0]       prdata_r;
	logic [7:0]        capacity_r;
	logic [7:0]        tim0_r;
	logic [7:0]        tim1_r;
	logic [7:0]        tim2_r;
	logic [7:0]        cfg_r;
	logic [15:0]       pdiv_r;
	logic [FS_AW-1:0]  fs_addr_r;
	logic [PAL_AW-1:0] pal_addr_r;
	logic              init_busy_r;
	logic              init_done_r;
	logic [31:0]       init_cnt_r;
	logic [15:0]       ref_cnt_r;
	logic              ref_due_r;
	logic [15:0]       pclk_cnt_r;
	logic              pclk_r;
	logic [15:0]       h_r;
	logic [15:0]       v_r;
	logic [FS_AW-1:0]  pix_r;
	fetch_state_t      fstate_r;
	logic [15:0]       w0_r;
	logic [15:0]       w1_r;
	logic [23:0]       prep_r;
	logic              hs_n_r;
	logic              vs_n_r;
	logic              de_r;
	logic [23:0]       lines_r;

	logic              access;
	logic              mapped;
	logic              err_now;
	logic              wr_ok;
	logic [31:0]       rd_mux;
	logic [15:0]       half;
	logic [15:0]       ref_limit;
	logic              tick;
	logic              active;
	logic              shown;
	color_fmt_t        fmt;
	logic [FS_AW-1:0]  addr0;
	logic [7:0]        pbyte;
	logic [7:0]        r8;
	logic [7:0]        g8;
	logic [7:0]        b8;
	logic [5:0]        wt;
	logic [23:0]       rgb_w;
	logic [23:0]       bus_map;

	assign access = PSEL_IN & PENABLE_IN;
	assign fmt    = color_fmt_t'(cfg_r[FMT_LSB +: 3]);

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0;
		case (PADDR_IN)
			OFS_CAPACITY: rd_mux = {24'h0, capacity_r};
			OFS_TIMING0:  rd_mux = {24'h0, tim0_r};
			OFS_TIMING1:  rd_mux = {24'h0, tim1_r};
			OFS_TIMING2:  rd_mux = {24'h0, tim2_r};
			OFS_INIT:     rd_mux = {30'h0, init_busy_r, init_done_r};
			OFS_DISP_CFG: rd_mux = {24'h0, cfg_r};
			OFS_PCLK0:    rd_mux = {24'h0, pdiv_r[7:0]};
			OFS_PCLK1:    rd_mux = {24'h0, pdiv_r[15:8]};
			OFS_FS_ADDR:  rd_mux = {11'h0, fs_addr_r};
			OFS_FS_DATA:  rd_mux = 32'h0;
			OFS_PAL_ADDR: rd_mux = {26'h0, pal_addr_r};
			OFS_PAL_DATA: rd_mux = 32'h0;
			default:      mapped = 1'b0;
		endcase
	end

	// Frame store writes before initialisation would land in an unrefreshed array.
	assign err_now = ~mapped | (PWRITE_IN & (PADDR_IN == OFS_FS_DATA) & ~init_done_r);
	assign wr_ok   = access & pready_r & PWRITE_IN & ~err_now;

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= access & ~pready_r;
			pslverr_r <= access & ~pready_r & err_now;
			prdata_r  <= (access & ~pready_r & ~PWRITE_IN) ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			capacity_r <= CFG_RESET;
			tim0_r     <= CFG_RESET;
			tim1_r     <= CFG_RESET;
			tim2_r     <= CFG_RESET;
			cfg_r      <= CFG_RESET;
			pdiv_r     <= PCLK_RESET;
			fs_addr_r  <= '0;
			pal_addr_r <= '0;
		end else if (wr_ok) begin
			case (PADDR_IN)
				OFS_CAPACITY: capacity_r <= PWDATA_IN[7:0];
				OFS_TIMING0:  tim0_r     <= PWDATA_IN[7:0];
				OFS_TIMING1:  tim1_r     <= PWDATA_IN[7:0];
				OFS_TIMING2:  tim2_r     <= PWDATA_IN[7:0];
				OFS_DISP_CFG: cfg_r      <= PWDATA_IN[7:0];
				OFS_PCLK0:    pdiv_r[7:0]  <= PWDATA_IN[7:0];
				OFS_PCLK1:    pdiv_r[15:8] <= PWDATA_IN[7:0];
				OFS_FS_ADDR:  fs_addr_r  <= PWDATA_IN[FS_AW-1:0];
				OFS_FS_DATA:  fs_addr_r  <= fs_addr_r + 1'b1;
				OFS_PAL_ADDR: pal_addr_r <= PWDATA_IN[PAL_AW-1:0];
				OFS_PAL_DATA: pal_addr_r <= pal_addr_r + 1'b1;
				default: begin
				end
			endcase
		end
	end

	assign fs.we     = wr_ok & (PADDR_IN == OFS_FS_DATA);
	assign fs.waddr  = fs_addr_r;
	assign fs.wdata  = PWDATA_IN[FS_DW-1:0];
	assign pal.we    = wr_ok & (PADDR_IN == OFS_PAL_DATA);
	assign pal.waddr = pal_addr_r;
	assign pal.wdata = PWDATA_IN[PAL_DW-1:0];

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			init_busy_r <= 1'b0;
			init_done_r <= 1'b0;
			init_cnt_r  <= 32'h0;
		end else if (wr_ok & (PADDR_IN == OFS_INIT) & PWDATA_IN[INIT_START_BIT]) begin
			init_busy_r <= 1'b1;
			init_done_r <= 1'b0;
			init_cnt_r  <= 32'h0;
		end else if (init_busy_r) begin
			if (init_cnt_r == 32'(INIT_CYCLES - 1)) begin
				init_busy_r <= 1'b0;
				init_done_r <= 1'b1;
			end else begin
				init_cnt_r <= init_cnt_r + 32'h1;
			end
		end
	end

	// A zero interval in the timing registers falls back to the 64 ms spread over all rows.
	assign ref_limit = ({tim2_r, tim1_r} != 16'h0) ? {tim2_r, tim1_r} : 16'(REFRESH_CYCLES);

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN | ~init_done_r) begin
			ref_cnt_r <= 16'h0;
			ref_due_r <= 1'b0;
		end else if (ref_cnt_r >= ref_limit - 16'h1) begin
			ref_cnt_r <= 16'h0;
			ref_due_r <= 1'b1;
		end else begin
			ref_cnt_r <= ref_cnt_r + 16'h1;
			if (fstate_r == F_RD0) begin
				ref_due_r <= 1'b0;
			end
		end
	end

	// The half period is floored so a whole fetch with one refresh stall fits a pixel.
	assign half = (pdiv_r < MIN_HALF) ? MIN_HALF : pdiv_r;
	assign tick = (pclk_cnt_r >= half - 16'h1) & pclk_r;

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			pclk_cnt_r <= 16'h0;
			pclk_r     <= 1'b0;
		end else if (pclk_cnt_r >= half - 16'h1) begin
			pclk_cnt_r <= 16'h0;
			pclk_r     <= ~pclk_r;
		end else begin
			pclk_cnt_r <= pclk_cnt_r + 16'h1;
		end
	end

	assign active = (h_r < 16'(H_ACTIVE)) & (v_r < 16'(V_ACTIVE));
	assign shown  = init_done_r & cfg_r[ENABLE_BIT];

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			h_r   <= 16'h0;
			v_r   <= 16'h0;
			pix_r <= '0;
		end else if (tick) begin
			if (h_r == 16'(H_TOTAL - 1)) begin
				h_r <= 16'h0;
				if (v_r == 16'(V_TOTAL - 1)) begin
					v_r   <= 16'h0;
					pix_r <= '0;
				end else begin
					v_r <= v_r + 16'h1;
				end
			end else begin
				h_r <= h_r + 16'h1;
			end
			if (active) begin
				pix_r <= pix_r + 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			hs_n_r  <= 1'b1;
			vs_n_r  <= 1'b1;
			de_r    <= 1'b0;
			lines_r <= 24'h0;
		end else if (tick) begin
			hs_n_r  <= ~((h_r >= 16'(H_ACTIVE + H_FRONT)) & (h_r < 16'(H_ACTIVE + H_FRONT + H_SYNC)));
			vs_n_r  <= ~((v_r >= 16'(V_ACTIVE + V_FRONT)) & (v_r < 16'(V_ACTIVE + V_FRONT + V_SYNC)));
			de_r    <= active & shown;
			lines_r <= (active & shown) ? bus_map : 24'h0;
		end
	end

	always_comb begin
		case (fmt)
			FMT_RGB888: addr0 = FS_AW'(({1'b0, pix_r[FS_AW-1:1]} * 22'h3) + pix_r[0]);
			FMT_RGB565: addr0 = pix_r;
			FMT_ARGB4444: addr0 = pix_r;
			default: addr0 = {1'b0, pix_r[FS_AW-1:1]};
		endcase
	end

	assign fs.raddr  = (fstate_r == F_RD1) ? addr0 + 1'b1 : addr0;
	assign pbyte     = pix_r[0] ? w0_r[15:8] : w0_r[7:0];
	assign pal.raddr = pbyte[PAL_AW-1:0];

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			fstate_r <= F_IDLE;
			w0_r     <= 16'h0;
			w1_r     <= 16'h0;
			prep_r   <= 24'h0;
		end else begin
			case (fstate_r)
				F_IDLE: begin
					if (tick & init_done_r) begin
						fstate_r <= F_RD0;
					end
				end
				F_RD0: begin
					if (~ref_due_r) begin
						fstate_r <= F_RD1;
					end
				end
				F_RD1: begin
					w0_r     <= fs.rdata;
					fstate_r <= F_RD2;
				end
				F_RD2: begin
					w1_r     <= fs.rdata;
					fstate_r <= F_PAL;
				end
				F_PAL: begin
					prep_r   <= rgb_w;
					fstate_r <= F_IDLE;
				end
				default: fstate_r <= F_IDLE;
			endcase
		end
	end

	always_comb begin
		r8 = 8'h0;
		g8 = 8'h0;
		b8 = 8'h0;
		wt = W_FULL;
		case (fmt)
			FMT_RGB332: begin
				r8 = {pbyte[7:5], 5'h0};
				g8 = {pbyte[4:2], 5'h0};
				b8 = {pbyte[1:0], 6'h0};
			end
			FMT_RGB565: begin
				r8 = {w0_r[15:11], 3'h0};
				g8 = {w0_r[10:5], 2'h0};
				b8 = {w0_r[4:0], 3'h0};
			end
			FMT_RGB888: begin
				b8 = pix_r[0] ? w0_r[15:8] : w0_r[7:0];
				g8 = pix_r[0] ? w1_r[7:0] : w0_r[15:8];
				r8 = pix_r[0] ? w1_r[15:8] : w1_r[7:0];
			end
			FMT_IDX26: begin
				r8 = {pal.rdata[11:8], 4'h0};
				g8 = {pal.rdata[7:4], 4'h0};
				b8 = {pal.rdata[3:0], 4'h0};
				case (pbyte[7:6])
					2'h0: wt = W_ZERO;
					2'h1: wt = W_IDX1;
					2'h2: wt = W_IDX2;
					default: wt = W_FULL;
				endcase
			end
			FMT_ARGB4444: begin
				r8 = {w0_r[11:8], 4'h0};
				g8 = {w0_r[7:4], 4'h0};
				b8 = {w0_r[3:0], 4'h0};
				wt = (w0_r[15:12] == A4_FULL) ? W_FULL : {1'b0, w0_r[15:12], 1'b0};
			end
			default: begin
			end
		endcase
	end

	// Weighting is against black; there is no second layer to blend with here.
	assign rgb_w = {8'((14'(r8) * 14'(wt)) >> 5),
	                8'((14'(g8) * 14'(wt)) >> 5),
	                8'((14'(b8) * 14'(wt)) >> 5)};

	always_comb begin
		case (bus_width_t'(cfg_r[BUSW_LSB +: 2]))
			BUS_16: bus_map = {prep_r[23:19], 3'h0, prep_r[15:10], 2'h0,
			                   prep_r[7:3], 3'h0};
			BUS_18: bus_map = {prep_r[23:18], 2'h0, prep_r[15:10], 2'h0,
			                   prep_r[7:2], 2'h0};
			default: bus_map = prep_r;
		endcase
	end

	assign PRDATA_OUT            = prdata_r;
	assign PREADY_OUT            = pready_r;
	assign PSLVERR_OUT           = pslverr_r;
	assign PCLK_OUT              = pclk_r;
	assign HSYNC_N_OUT           = hs_n_r;
	assign VSYNC_N_OUT           = vs_n_r;
	assign DE_OUT                = de_r;
	assign PANEL_PIXEL_LINES_OUT = lines_r;
endmodule

// >>> core/mem_port_if.sv
// One write port and one read port of a word memory.
// Assumes both sides run on the same core clock.
interface mem_port_if #(
	parameter int AW = 6,
	parameter int DW = 12
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> core/panel_out_pkg.sv
// Constants, register map and field layout shared by the frame memory and panel output block.
// Assumes a single core clock at the rate named below; all counts derive from it.
package panel_out_pkg;

	localparam int CLK_MHZ        = 250;
	localparam int REFRESH_MS     = 64;
	localparam int REFRESH_ROWS   = 4096;
	localparam int REFRESH_CYCLES = (REFRESH_MS * 1000 * CLK_MHZ) / REFRESH_ROWS;
	localparam int INIT_US        = 200;
	localparam int INIT_CYCLES    = INIT_US * CLK_MHZ;

	localparam int FS_MBIT  = 32;
	localparam int FS_DW    = 16;
	localparam int FS_DEPTH = (FS_MBIT * 1024 * 1024) / FS_DW;
	localparam int FS_AW    = 21;
	localparam int PAL_DEPTH = 64;
	localparam int PAL_AW    = 6;
	localparam int PAL_DW    = 12;

	localparam logic [11:0] OFS_CAPACITY = 12'h000;
	localparam logic [11:0] OFS_TIMING0  = 12'h004;
	localparam logic [11:0] OFS_TIMING1  = 12'h008;
	localparam logic [11:0] OFS_TIMING2  = 12'h00c;
	localparam logic [11:0] OFS_INIT     = 12'h010;
	localparam logic [11:0] OFS_DISP_CFG = 12'h014;
	localparam logic [11:0] OFS_PCLK0    = 12'h018;
	localparam logic [11:0] OFS_PCLK1    = 12'h01c;
	localparam logic [11:0] OFS_FS_ADDR  = 12'h020;
	localparam logic [11:0] OFS_FS_DATA  = 12'h024;
	localparam logic [11:0] OFS_PAL_ADDR = 12'h028;
	localparam logic [11:0] OFS_PAL_DATA = 12'h02c;

	localparam int INIT_START_BIT = 0;
	localparam int INIT_DONE_BIT  = 0;
	localparam int INIT_BUSY_BIT  = 1;
	localparam int ENABLE_BIT     = 0;
	localparam int BUSW_LSB       = 3;
	localparam int FMT_LSB        = 5;

	localparam logic [7:0]  CFG_RESET   = 8'h00;
	localparam logic [15:0] PCLK_RESET  = 16'h0004;
	localparam logic [15:0] MIN_HALF    = 16'h0003;

	localparam logic [5:0] W_ZERO = 6'h00;
	localparam logic [5:0] W_IDX1 = 6'h0b;
	localparam logic [5:0] W_IDX2 = 6'h14;
	localparam logic [5:0] W_FULL = 6'h20;
	localparam logic [3:0] A4_FULL = 4'hf;

	typedef enum logic [1:0] {
		BUS_24 = 2'b00,
		BUS_18 = 2'b01,
		BUS_16 = 2'b10
	} bus_width_t;

	typedef enum logic [2:0] {
		FMT_RGB332   = 3'h0,
		FMT_RGB565   = 3'h1,
		FMT_RGB888   = 3'h2,
		FMT_IDX26    = 3'h3,
		FMT_ARGB4444 = 3'h4
	} color_fmt_t;

endpackage

// >>> core/word_mem.sv
// Simple dual-port word memory with registered read data.
// Assumes the read address is presented one cycle before the data is used.
module word_mem #(
	parameter int DEPTH = 64
) (
	input  wire logic  MCLK_IN,
	mem_port_if.mem    port
);
	logic [$bits(port.wdata)-1:0] store [DEPTH];

	always_ff @(posedge MCLK_IN) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		port.rdata <= store[port.raddr];
	end
endmodule

// >>> tb/frame_memory_pixel_panel_out_asserts.sv
// Checker for the frame memory and panel output block.
// Assumes it is bound to the top module and sees only its ports.
module frame_memory_pixel_panel_out_asserts
	import panel_out_pkg::*;
#(
	parameter int INIT_CYCLES = 20
) (
	input wire logic        MCLK_IN,
	input wire logic        RST_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic        PCLK_OUT,
	input wire logic        HSYNC_N_OUT,
	input wire logic        VSYNC_N_OUT,
	input wire logic        DE_OUT,
	input wire logic [23:0] PANEL_PIXEL_LINES_OUT
);
	logic        acc;
	logic        cfg_wr;
	logic        rd_init;
	logic [7:0]  cfg_r;
	logic [7:0]  settle_r;
	logic [15:0] cnt_r;
	logic        started_r;
	assign acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
	assign cfg_wr = acc && PWRITE_IN && PADDR_IN == OFS_DISP_CFG;
	assign rd_init = acc && !PWRITE_IN && PADDR_IN == OFS_INIT;
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN)
			cfg_r <= 8'h00;
		else if (cfg_wr)
			cfg_r <= PWDATA_IN[7:0];
	end
	// The output lags a new setting by a pixel and a fetch, so checks wait for it to settle.
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN || cfg_wr)
			settle_r <= 8'h00;
		else if (settle_r != 8'hff)
			settle_r <= settle_r + 8'h01;
	end
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			cnt_r <= 16'h0000;
			started_r <= 1'b0;
		end else if (acc && PWRITE_IN && PADDR_IN == OFS_INIT && PWDATA_IN[0]) begin
			cnt_r <= 16'h0000;
			started_r <= 1'b1;
		end else if (cnt_r != 16'hffff)
			cnt_r <= cnt_r + 16'h0001;
	end
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);
	apb_wait_a: assert property ((PSEL_IN && !PENABLE_IN) ##1 (PSEL_IN && PENABLE_IN)
		|=> PREADY_OUT) else $error("ready not one cycle after access");
	err_with_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
	init_early_a: assert property (rd_init && cnt_r < INIT_CYCLES - 2 |-> !PRDATA_OUT[0])
		else $error("init done too early");
	init_late_a: assert property (rd_init && started_r && cnt_r > INIT_CYCLES + 4
		|-> PRDATA_OUT[0]) else $error("init done missing");
	pclk_half_a: assert property ($changed(PCLK_OUT) |=> $stable(PCLK_OUT)[*2])
		else $error("pixel clock half period short");
	lines_fall_a: assert property ($changed(PANEL_PIXEL_LINES_OUT) |-> $fell(PCLK_OUT))
		else $error("lines changed off falling edge");
	blank_zero_a: assert property (!DE_OUT |-> PANEL_PIXEL_LINES_OUT == 24'h000000)
		else $error("lines not zero while blank");
	de_enable_a: assert property (DE_OUT && settle_r == 8'hff |-> cfg_r[ENABLE_BIT])
		else $error("data enable while disabled");
	narrow_low_a: assert property (DE_OUT && settle_r == 8'hff && cfg_r[4:3] inside {2'b01, 2'b10}
		|-> (PANEL_PIXEL_LINES_OUT & (cfg_r[4] ? 24'h070307 : 24'h030303)) == 24'h000000)
		else $error("unused lines not low");
	cover property (rd_init && PRDATA_OUT[0]);
	cover property ($rose(DE_OUT));
	cover property (PSLVERR_OUT);
endmodule
bind frame_memory_pixel_panel_out frame_memory_pixel_panel_out_asserts #(
	.INIT_CYCLES(INIT_CYCLES)
) chk (
	.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
	.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.PCLK_OUT(PCLK_OUT), .HSYNC_N_OUT(HSYNC_N_OUT), .VSYNC_N_OUT(VSYNC_N_OUT),
	.DE_OUT(DE_OUT), .PANEL_PIXEL_LINES_OUT(PANEL_PIXEL_LINES_OUT)
);

// >>> tb/panel_sink.sv
// Panel driver model that watches the parallel RGB bus.
// Assumes the panel samples lines and data enable on rising pixel clock.
module panel_sink (
	input  wire logic        pclk_in,
	input  wire logic        clr_in,
	input  wire logic        de_in,
	input  wire logic        hs_n_in,
	input  wire logic        vs_n_in,
	input  wire logic [23:0] lines_in,
	output logic      [23:0] seen_out,
	output logic             diff_out,
	output int               n_out,
	output int               line_out,
	output int               frame_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hs_q   = 1'b1;
	logic vs_q   = 1'b1;
	int   px_cnt = 0;
	int   ln_cnt = 0;
	// Line and frame lengths are measured between sync falls, so a partial first line is
	// overwritten long before anyone reads the result.
	always @(posedge pclk_in) begin
		hs_q <= hs_n_in;
		vs_q <= vs_n_in;
		if (hs_q && !hs_n_in) begin
			line_out <= px_cnt;
			px_cnt <= 1;
		end else
			px_cnt <= px_cnt + 1;
		if (vs_q && !vs_n_in) begin
			frame_out <= ln_cnt;
			ln_cnt <= 0;
		end else if (hs_q && !hs_n_in)
			ln_cnt <= ln_cnt + 1;
	end
	// Any two pixels that differ inside one window are flagged, so a stale pixel cannot hide.
	always @(posedge pclk_in) begin
		if (clr_in) begin
			n_out <= 0;
			diff_out <= 1'b0;
		end else if (de_in === 1'b1) begin
			if (n_out > 0 && lines_in !== seen_out)
				diff_out <= 1'b1;
			seen_out <= lines_in;
			n_out <= n_out + 1;
		end
	end
endmodule

// >>> tb/testbench.sv
// Self-checking bench: APB host on one side, panel model on the other.
// Assumes a shrunken raster and init count so every format and bus width fits one run.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import panel_out_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic        clr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd, r, seed;
	logic        pready, pslverr, pclk, hs_n, vs_n, de, er;
	logic [23:0] lines, seen;
	logic [15:0] w;
	logic [5:0]  k;
	logic        diff;
	int          num_errors = 0;
	int          n_checks = 0;
	int          n_px, i;
	int          line_px, frame_ln;
	// Front porch and sync width stay at their defaults; only active area and back porch shrink.
	localparam int LINE_PX  = 4 + 20 + 10 + 2;
	localparam int FRAME_LN = 2 + 4 + 2 + 1;
	frame_memory_pixel_panel_out #(.INIT_CYCLES(20), .H_ACTIVE(4), .H_BACK(2), .V_ACTIVE(2),
		.V_BACK(1)) DUT (
		.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .PCLK_OUT(pclk), .HSYNC_N_OUT(hs_n), .VSYNC_N_OUT(vs_n),
		.DE_OUT(de), .PANEL_PIXEL_LINES_OUT(lines));
	panel_sink sink (.pclk_in(pclk), .clr_in(clr), .de_in(de), .hs_n_in(hs_n), .vs_n_in(vs_n),
		.lines_in(lines), .seen_out(seen), .diff_out(diff), .n_out(n_px), .line_out(line_px),
		.frame_out(frame_ln));
	initial begin
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Colour 8'h80 keeps every opacity weight exact, so no rounding guess is needed.
	function automatic logic [23:0] exp_px(input int f, input int b, input logic [15:0] v);
		logic [7:0] cr, cg, cb;
		int wt;
		wt = 32;
		cr = 8'h80;
		cg = 8'h80;
		cb = 8'h80;
		case (f)
			0: {cr, cg, cb} = {v[7:5], 5'h00, v[4:2], 5'h00, v[1:0], 6'h00};
			1: {cr, cg, cb} = {v[15:11], 3'h0, v[10:5], 2'h0, v[4:0], 3'h0};
			2: {cr, cg, cb} = {v[7:0], v[7:0], v[7:0]};
			3: wt = v[7:6] == 2'h0 ? 0 : v[7:6] == 2'h1 ? 11 : v[7:6] == 2'h2 ? 20 : 32;
			default: wt = v[15:12] == 4'hf ? 32 : 2 * v[15:12];
		endcase
		cr = 8'((cr * wt) >> 5);
		cg = 8'((cg * wt) >> 5);
		cb = 8'((cb * wt) >> 5);
		if (b == 2)
			return {cr[7:3], 3'h0, cg[7:2], 2'h0, cb[7:3], 3'h0};
		if (b == 1)
			return {cr[7:2], 2'h0, cg[7:2], 2'h0, cb[7:2], 2'h0};
		return {cr, cg, cb};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rd = prdata;
		er = pslverr;
		if (t >= 20)
			num_errors++;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic watch(input int n);
		repeat (700) @(posedge clk);
		clr <= 1'b1;
		repeat (20) @(posedge clk);
		clr <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	initial begin
		#320000;
		num_errors++;
		final_report();
	end
	initial begin
		seed = 32'h00017dcd;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("reset outputs", 32'h00000006, {pready, pslverr, pclk, hs_n, vs_n, de});
		chk("reset lines", 32'h00000000, lines);
		r = rnd();
		apb(1'b1, OFS_CAPACITY, r);
		apb(1'b0, OFS_CAPACITY, 32'h0);
		chk("capacity", {24'h000000, r[7:0]}, rd);
		for (i = 0; i < 3; i++) begin
			r = rnd();
			apb(1'b1, OFS_TIMING0 + 12'(4 * i), r);
			apb(1'b0, OFS_TIMING0 + 12'(4 * i), 32'h0);
			chk("timing", {24'h000000, r[7:0]}, rd);
			apb(1'b1, OFS_TIMING0 + 12'(4 * i), 32'h0);
		end
		apb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped", 32'h00000001, {rd[30:0], er});
		apb(1'b1, OFS_FS_DATA, 32'h1);
		chk("store before init", 32'h00000001, er);
		apb(1'b1, OFS_INIT, 32'h1);
		apb(1'b0, OFS_INIT, 32'h0);
		chk("init early", 32'h00000000, rd[0]);
		i = 0;
		do begin
			apb(1'b0, OFS_INIT, 32'h0);
			i++;
		end while (rd[0] !== 1'b1 && i < 40);
		chk("init done", 32'h00000001, rd[0]);
		apb(1'b1, OFS_PCLK0, 32'h3);
		apb(1'b1, OFS_PCLK1, 32'h0);
		apb(1'b0, OFS_INIT, 32'h0);
		chk("init held", 32'h00000001, rd[1:0]);
		r = rnd();
		k = r[5:0];
		apb(1'b1, OFS_PAL_ADDR, 32'h0);
		for (i = 0; i < 64; i++)
			apb(1'b1, OFS_PAL_DATA, i == k ? 32'h888 : rnd() & 32'hfff);
		for (int f = 0; f < 5; f++) begin
			for (int b = 0; b < 3; b++) begin
				r = rnd();
				case (f)
					1: w = r[15:0];
					3: w = {r[7:6], k, r[7:6], k};
					4: w = {r[15:12], 12'h888};
					default: w = {r[7:0], r[7:0]};
				endcase
				apb(1'b1, OFS_FS_ADDR, 32'h0);
				repeat (16) apb(1'b1, OFS_FS_DATA, {16'h0000, w});
				apb(1'b1, OFS_DISP_CFG, 32'(1 | (b << BUSW_LSB) | (f << FMT_LSB)));
				watch(2000);
				chk("pixel", exp_px(f, b, w), seen);
				chk("uniform", 32'h00000000, diff);
				chk("pixels seen", 32'h00000001, n_px > 0);
			end
		end
		apb(1'b1, OFS_DISP_CFG, 32'h0);
		watch(2000);
		chk("disabled pixels", 32'h00000000, n_px);
		chk("line length", 32'(LINE_PX), line_px);
		chk("frame lines", 32'(FRAME_LN), frame_ln);
		final_report();
	end
endmodule
